// >>> pshc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pshc_ctrl (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	// serial control port
	input  wire logic       cclk,
	input  wire logic       cs_n,
	input  wire logic       ci,
	// timing format, high for delayed
	input  wire logic       delayed_mode,
	// pcm highway
	input  wire logic       bclk,
	input  wire logic       tx_frame_sync,
	input  wire logic       rx_frame_sync,
	input  wire logic       rx_pcm_in_a,
	input  wire logic       rx_pcm_in_b,
	output logic            tx_pcm_out_a,
	output logic            tx_pcm_out_a_oe,
	output logic            tx_pcm_out_b,
	output logic            tx_pcm_out_b_oe,
	// codec samples
	input  wire logic [7:0] tx_sample,
	output logic [7:0]      rx_sample,
	output logic            rx_sample_valid,
	// gain and hybrid settings
	output logic [7:0]      tx_gain_code,
	output logic [7:0]      rx_gain_code,
	output logic            tx_mute,
	output logic            rx_mute,
	output logic [7:0]      echo_cancel_ctrl_one,
	output logic            cancel_en,
	output logic            cancel_noninvert,
	output logic            first_order_en,
	output logic [4:0]      cancel_attenuation
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] sync3_r;
	logic       cclk_s, cs_n_s, ci_s, bclk_s;
	logic       cclk_p, cs_n_p, bclk_p;
	logic [1:0] fs_s;
	logic       dra_s, drb_s;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			sync3_r <= 8'h00;
		end else if (clk_en) begin
			sync1_r <= {cclk, cs_n, ci, bclk, rx_frame_sync,
				tx_frame_sync, rx_pcm_in_a, rx_pcm_in_b};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	assign {cclk_s, cs_n_s, ci_s, bclk_s, fs_s, dra_s, drb_s} = sync2_r;
	assign cclk_p = sync3_r[7];
	assign cs_n_p = sync3_r[6];
	assign bclk_p = sync3_r[4];

	logic cclk_rise, cs_rise, bclk_rise, bclk_fall;
	assign cclk_rise = cclk_s & ~cclk_p;
	assign cs_rise = cs_n_s & ~cs_n_p;
	assign bclk_rise = bclk_s & ~bclk_p;
	assign bclk_fall = ~bclk_s & bclk_p;

	// ----------------------------------------
	// control byte receiver
	// ----------------------------------------
	logic [7:0] sh_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] cmd_r;
	logic       byte_done;
	logic       wr_commit;
	logic [5:0] wr_slot;
	pshc_pkg::pshc_stage_e stage_r;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sh_r <= 8'h00;
			bit_cnt_r <= 4'h0;
		end else if (clk_en) begin
			if (cs_n_s) begin
				bit_cnt_r <= 4'h0;
			end else if (cclk_rise) begin
				sh_r <= {sh_r[6:0], ci_s};
				if (bit_cnt_r != pshc_pkg::BYTE_BITS) begin
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
			end
		end
	end

	// a select window with fewer than eight clocks is dropped; extra clocks keep the last eight bits
	assign byte_done = cs_rise && (bit_cnt_r == pshc_pkg::BYTE_BITS);
	assign wr_commit = byte_done && (stage_r == pshc_pkg::PSHC_WAIT_DATA);
	assign wr_slot = sh_r[pshc_pkg::SLOT_MSB:0];

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			stage_r <= pshc_pkg::PSHC_WAIT_CMD;
			cmd_r <= 8'h00;
		end else if (clk_en && byte_done) begin
			case (stage_r)
				pshc_pkg::PSHC_WAIT_CMD: begin
					cmd_r <= sh_r;
					stage_r <= pshc_pkg::PSHC_WAIT_DATA;
				end
				default: begin
					stage_r <= pshc_pkg::PSHC_WAIT_CMD;
				end
			endcase
		end
	end

	// ----------------------------------------
	// gain and hybrid registers
	// ----------------------------------------
	logic [7:0] tx_gain_r, rx_gain_r, echo_r;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tx_gain_r <= pshc_pkg::TX_GAIN_RST;
			rx_gain_r <= pshc_pkg::RX_GAIN_RST;
			echo_r <= pshc_pkg::ECHO_ONE_RST;
		end else if (clk_en && wr_commit) begin
			if (cmd_r == pshc_pkg::CMD_TX_GAIN) begin
				tx_gain_r <= sh_r;
			end else if (cmd_r == pshc_pkg::CMD_RX_GAIN) begin
				rx_gain_r <= sh_r;
			end else if (cmd_r == pshc_pkg::CMD_ECHO_ONE) begin
				echo_r <= sh_r;
			end
		end
	end

	assign tx_gain_code = tx_gain_r;
	assign rx_gain_code = rx_gain_r;
	assign tx_mute = (tx_gain_r == 8'h00);
	assign rx_mute = (rx_gain_r == 8'h00);
	// analog chain runs biquad, first order, attenuator; biquad mode
	// lives in a later register, so only its bypass order shows here
	assign echo_cancel_ctrl_one = echo_r;
	assign cancel_en = echo_r[pshc_pkg::CANCEL_EN_BIT];
	assign cancel_noninvert = echo_r[pshc_pkg::PHASE_BIT];
	assign first_order_en = echo_r[pshc_pkg::FIRST_ORDER_BIT];
	assign cancel_attenuation = echo_r[pshc_pkg::ATTEN_MSB:0];

	// ----------------------------------------
	// slot assignment, index 0 transmit, 1 receive
	// ----------------------------------------
	logic [1:0] fs_lvl_r, fs_start, cmd_hit, apply;
	logic [1:0] en_pend_r, port_pend_r, en_act_r, port_act_r;
	logic [1:0] en_nxt, port_nxt, in_slot;
	logic [1:0] pend_cnt_r [2];
	logic [5:0] slot_pend_r [2];
	logic [5:0] slot_act_r [2];
	logic [5:0] slot_nxt [2];
	logic [9:0] pos_r [2];
	logic [9:0] pos_nxt [2];

	for (genvar i = 0; i < 2; i++) begin : g_dir
		assign fs_start[i] = bclk_rise & fs_s[i] & ~fs_lvl_r[i];
		assign cmd_hit[i] = wr_commit && (cmd_r == (i == 0 ?
			pshc_pkg::CMD_TX_SLOT : pshc_pkg::CMD_RX_SLOT));
		// a write in the apply cycle restarts the two-frame wait
		assign apply[i] = fs_start[i] && !cmd_hit[i] &&
			(pend_cnt_r[i] == 2'h1);
		assign en_nxt[i] = apply[i] ? en_pend_r[i] : en_act_r[i];
		assign port_nxt[i] = apply[i] ? port_pend_r[i] : port_act_r[i];
		assign slot_nxt[i] = apply[i] ? slot_pend_r[i] : slot_act_r[i];

		always_comb begin
			if (fs_start[i]) begin
				// delayed format holds the first bit back one clock
				pos_nxt[i] = delayed_mode ? pshc_pkg::POS_DELAYED :
					pshc_pkg::POS_PROMPT;
			end else if (bclk_rise && pos_r[i] != pshc_pkg::POS_IDLE) begin
				pos_nxt[i] = pos_r[i] + 10'h001;
			end else begin
				pos_nxt[i] = pos_r[i];
			end
		end

		// fixed mode always uses slot 0; counter stops after slot 63
		assign in_slot[i] = en_nxt[i] && (pos_nxt[i] < pshc_pkg::POS_IDLE) &&
			(pos_nxt[i][8:3] == (delayed_mode ? slot_nxt[i] : 6'h00));

		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				fs_lvl_r[i] <= 1'b0;
				pos_r[i] <= pshc_pkg::POS_IDLE;
			end else if (clk_en) begin
				if (bclk_rise) begin
					fs_lvl_r[i] <= fs_s[i];
				end
				pos_r[i] <= pos_nxt[i];
			end
		end

		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				slot_pend_r[i] <= pshc_pkg::SLOT_RST;
				en_pend_r[i] <= 1'b0;
				port_pend_r[i] <= 1'b0;
				pend_cnt_r[i] <= 2'h0;
			end else if (clk_en) begin
				if (cmd_hit[i]) begin
					slot_pend_r[i] <= wr_slot;
					en_pend_r[i] <= sh_r[pshc_pkg::SLOT_EN_BIT];
					port_pend_r[i] <= sh_r[pshc_pkg::PORT_SEL_BIT];
					pend_cnt_r[i] <= pshc_pkg::APPLY_FRAMES;
				end else if (fs_start[i] && pend_cnt_r[i] != 2'h0) begin
					pend_cnt_r[i] <= pend_cnt_r[i] - 2'h1;
				end
			end
		end

		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				slot_act_r[i] <= pshc_pkg::SLOT_RST;
				en_act_r[i] <= 1'b0;
				port_act_r[i] <= 1'b0;
			end else if (clk_en) begin
				slot_act_r[i] <= slot_nxt[i];
				en_act_r[i] <= en_nxt[i];
				port_act_r[i] <= port_nxt[i];
			end
		end
	end

	// ----------------------------------------
	// transmit shifter
	// ----------------------------------------
	logic [7:0] tx_sh_r;
	logic       tx_bit_r, tx_oe_a_r, tx_oe_b_r;
	logic       tx_head;
	assign tx_head = tx_sample[7];

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tx_sh_r <= 8'h00;
			tx_bit_r <= 1'b0;
			tx_oe_a_r <= 1'b0;
			tx_oe_b_r <= 1'b0;
		end else if (clk_en && bclk_rise) begin
			tx_oe_a_r <= in_slot[0] & ~port_nxt[0];
			tx_oe_b_r <= in_slot[0] & port_nxt[0];
			if (in_slot[0] && pos_nxt[0][2:0] == 3'h0) begin
				tx_bit_r <= tx_head;
				tx_sh_r <= {tx_sample[6:0], 1'b0};
			end else if (in_slot[0]) begin
				tx_bit_r <= tx_sh_r[7];
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
		end
	end

	assign tx_pcm_out_a = tx_bit_r;
	assign tx_pcm_out_b = tx_bit_r;
	assign tx_pcm_out_a_oe = tx_oe_a_r;
	assign tx_pcm_out_b_oe = tx_oe_b_r;

	// ----------------------------------------
	// receive shifter, sampled on falling bit clock
	// ----------------------------------------
	logic [7:0] rx_sh_r, rx_word_r;
	logic [2:0] rx_bit_r;
	logic       rx_slot_r, rx_port_r, rx_valid_r, rx_din;
	assign rx_din = rx_port_r ? drb_s : dra_s;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rx_slot_r <= 1'b0;
			rx_port_r <= 1'b0;
			rx_bit_r <= 3'h0;
		end else if (clk_en && bclk_rise) begin
			rx_slot_r <= in_slot[1];
			rx_port_r <= port_nxt[1];
			rx_bit_r <= pos_nxt[1][2:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rx_sh_r <= 8'h00;
			rx_word_r <= 8'h00;
			rx_valid_r <= 1'b0;
		end else if (clk_en) begin
			rx_valid_r <= 1'b0;
			if (bclk_fall && rx_slot_r) begin
				rx_sh_r <= {rx_sh_r[6:0], rx_din};
				if (rx_bit_r == 3'h7) begin
					rx_word_r <= {rx_sh_r[6:0], rx_din};
					rx_valid_r <= 1'b1;
				end
			end
		end
	end

	assign rx_sample = rx_word_r;
	assign rx_sample_valid = rx_valid_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_port_excl;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		!(tx_pcm_out_a_oe && tx_pcm_out_b_oe);
	endproperty
	a_port_excl:
	assert property (p_port_excl) else $error("both transmit ports driven");

	property p_oe_needs_en;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		(tx_pcm_out_a_oe || tx_pcm_out_b_oe) |-> en_act_r[0];
	endproperty
	a_oe_needs_en:
	assert property (p_oe_needs_en) else $error("transmit driven while disabled");

	property p_slot_match;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		tx_pcm_out_a_oe |-> (pos_r[0] < pshc_pkg::POS_IDLE) &&
			(pos_r[0][8:3] == (delayed_mode ? slot_act_r[0] : 6'h00));
	endproperty
	a_slot_match:
	assert property (p_slot_match) else $error("transmit outside its slot");

	property p_frame_start;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		(fs_start[0] && !delayed_mode) |=> pos_r[0] == pshc_pkg::POS_PROMPT;
	endproperty
	a_frame_start:
	assert property (p_frame_start) else $error("frame sync did not restart slot 0");

	property p_slot_decode;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		cmd_hit[0] |=> slot_pend_r[0] == $past(wr_slot) && pend_cnt_r[0] == 2'h2;
	endproperty
	a_slot_decode:
	assert property (p_slot_decode) else $error("slot number not captured");

	property p_apply;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		apply[1] |=> slot_act_r[1] == slot_pend_r[1] && en_act_r[1] == en_pend_r[1];
	endproperty
	a_apply:
	assert property (p_apply) else $error("assignment not applied on second frame");

	property p_msb_first;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		(bclk_rise && in_slot[0] && pos_nxt[0][2:0] == 3'h0) |=>
			tx_pcm_out_a == $past(tx_head);
	endproperty
	a_msb_first:
	assert property (p_msb_first) else $error("first bit out is not the msb");

	property p_gain;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		(wr_commit && cmd_r == pshc_pkg::CMD_TX_GAIN) |=>
			tx_gain_code == $past(sh_r) && tx_mute == ($past(sh_r) == 8'h00);
	endproperty
	a_gain:
	assert property (p_gain) else $error("transmit gain write lost");

	property p_echo;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		(wr_commit && cmd_r == pshc_pkg::CMD_ECHO_ONE) |=>
			echo_cancel_ctrl_one == $past(sh_r) && cancel_en == $past(sh_r[7]);
	endproperty
	a_echo:
	assert property (p_echo) else $error("hybrid register write lost");

	property p_pwrup;
		@(posedge core_clk) disable iff (!rstn || !clk_en)
		$rose(rstn) |-> !cancel_en;
	endproperty
	a_pwrup:
	assert property (p_pwrup) else $error("cancellation on after reset");

endmodule
`default_nettype wire

// >>> pshc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pshc_ctrl_tb;
	logic       core_clk, rstn, clk_en, cclk, cs_n, ci, delayed_mode, fs, bclk;
	logic       rx_pcm_in_a, rx_pcm_in_b, rx_sample_valid;
	logic       tx_pcm_out_a, tx_pcm_out_a_oe, tx_pcm_out_b, tx_pcm_out_b_oe;
	logic       tx_mute, rx_mute, cancel_en, cancel_noninvert, first_order_en;
	logic [4:0] cancel_attenuation;
	logic [7:0] tx_sample, rx_sample, tx_gain_code, rx_gain_code, echo_cancel_ctrl_one;
	logic [7:0] ev [2] = '{8'ha5, 8'h58};
	int         n_errors, total_checks, n_valid;

	pshc_ctrl DUT (
		.core_clk, .rstn, .clk_en, .cclk, .cs_n, .ci, .delayed_mode, .bclk,
		.tx_frame_sync(fs), .rx_frame_sync(fs), .rx_pcm_in_a, .rx_pcm_in_b,
		.tx_pcm_out_a, .tx_pcm_out_a_oe, .tx_pcm_out_b, .tx_pcm_out_b_oe, .tx_sample,
		.rx_sample, .rx_sample_valid, .tx_gain_code, .rx_gain_code, .tx_mute, .rx_mute,
		.echo_cancel_ctrl_one, .cancel_en, .cancel_noninvert, .first_order_en,
		.cancel_attenuation
	);

	pshc_far far (
		.clk(core_clk), .bclk, .fs, .rx_a(rx_pcm_in_a), .rx_b(rx_pcm_in_b),
		.tx_a(tx_pcm_out_a), .tx_a_oe(tx_pcm_out_a_oe), .tx_b(tx_pcm_out_b),
		.tx_b_oe(tx_pcm_out_b_oe)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (rx_sample_valid === 1'b1) begin
			n_valid++;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// cclk phases of 4 cycles leave margin over the 2-stage synchronisers
	task automatic wbyte(input logic [7:0] b);
		cs_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		for (int i = 7; i >= 0; i--) begin
			ci <= b[i];
			cclk <= 1'b0;
			repeat (4) @(posedge core_clk);
			cclk <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
		cs_n <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask

	task automatic wreg(input logic [7:0] c, input logic [7:0] d);
		wbyte(c);
		wbyte(d);
		repeat (8) @(posedge core_clk);
	endtask

	task automatic wr_slots(input logic [7:0] v);
		wreg(pshc_pkg::CMD_TX_SLOT, v);
		wreg(pshc_pkg::CMD_RX_SLOT, v);
	endtask

	// same slot and port for both directions; en low expects a silent frame
	task automatic frm_chk(input int nb, input int pos0, input logic rp, input logic [7:0] rw,
		input logic en);
		int         v0;
		logic [7:0] nw;
		v0 = n_valid;
		nw = ~rw;
		tx_sample <= nw;
		far.frame(nb, pos0, rp, rw);
		chk(32'(far.first), en ? 32'(pos0) : 32'hffffffff);
		chk(32'(n_valid - v0), 32'(en));
		if (en) begin
			chk(32'(far.port), 32'(rp));
			chk(32'(far.n_oe), 32'h8);
			chk({24'h0, far.word}, {24'h0, nw});
			chk({24'h0, rx_sample}, {24'h0, rw});
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		cclk = 1'b0;
		cs_n = 1'b1;
		ci = 1'b0;
		delayed_mode = 1'b0;
		tx_sample = 8'h00;
		n_errors = 0;
		total_checks = 0;
		n_valid = 0;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({tx_gain_code, rx_gain_code, echo_cancel_ctrl_one, 8'h00}, 32'h0);
		chk({29'h0, tx_mute, rx_mute, cancel_en}, 32'h6);
		wreg(pshc_pkg::CMD_TX_GAIN, 8'hbf);
		wreg(pshc_pkg::CMD_RX_GAIN, 8'hae);
		// unknown select must leave both gain registers alone
		wreg(8'h70, 8'h33);
		chk({16'h0, tx_gain_code, rx_gain_code}, 32'hbfae);
		chk({30'h0, tx_mute, rx_mute}, 32'h0);
		// a frozen block must ignore a whole write
		clk_en <= 1'b0;
		wreg(pshc_pkg::CMD_TX_GAIN, 8'h11);
		clk_en <= 1'b1;
		chk(32'(tx_gain_code), 32'hbf);
		foreach (ev[i]) begin
			wreg(pshc_pkg::CMD_ECHO_ONE, ev[i]);
			chk(32'(echo_cancel_ctrl_one), 32'(ev[i]));
			chk({24'h0, cancel_en, cancel_noninvert, first_order_en, cancel_attenuation},
				32'(ev[i]));
		end
		wreg(pshc_pkg::CMD_RX_GAIN, 8'h00);
		chk({30'h0, tx_mute, rx_mute}, 32'h1);
		wr_slots(8'h80);
		frm_chk(65, 0, 1'b0, 8'h3c, 1'b0);
		frm_chk(65, 0, 1'b0, 8'h3c, 1'b1);
		delayed_mode <= 1'b1;
		wr_slots(8'h82);
		frm_chk(65, 1, 1'b0, 8'h69, 1'b1);
		frm_chk(65, 17, 1'b0, 8'h96, 1'b1);
		wr_slots(8'hc5);
		frm_chk(65, 17, 1'b0, 8'h11, 1'b1);
		frm_chk(65, 41, 1'b1, 8'h77, 1'b1);
		wr_slots(8'hbf);
		frm_chk(65, 41, 1'b1, 8'h22, 1'b1);
		frm_chk(513, 505, 1'b0, 8'h5a, 1'b1);
		wr_slots(8'h00);
		frm_chk(513, 505, 1'b0, 8'he1, 1'b1);
		frm_chk(65, 1, 1'b0, 8'hc3, 1'b0);
		// mid-run reset must drop cancellation and gains again
		wreg(pshc_pkg::CMD_ECHO_ONE, 8'h80);
		chk(32'(cancel_en), 32'h1);
		rstn <= 1'b0;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({16'h0, tx_gain_code, echo_cancel_ctrl_one}, 32'h0);
		chk({29'h0, tx_mute, rx_mute, cancel_en}, 32'h6);
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> pshc_far.sv
`timescale 1ns/1ps
`default_nettype none
module pshc_far (
	// clock
	input  wire logic clk,
	// pcm highway
	output logic      bclk,
	output logic      fs,
	output logic      rx_a,
	output logic      rx_b,
	input  wire logic tx_a,
	input  wire logic tx_a_oe,
	input  wire logic tx_b,
	input  wire logic tx_b_oe
);
	int         first;
	int         n_oe;
	logic       port;
	logic [7:0] word;

	initial begin
		bclk = 1'b0;
		fs = 1'b0;
		rx_a = 1'b0;
		rx_b = 1'b0;
	end

	// ----------------------------------------
	// frame generation, 200 ns bit clock
	// ----------------------------------------
	task automatic half();
		repeat (4) @(posedge clk);
	endtask

	// pos0 is the bit index of the driven word; other bits toggle so stale data never matches
	task automatic frame(input int nb, input int pos0, input logic rp, input logic [7:0] rw);
		logic b;
		first = -1;
		n_oe = 0;
		word = 8'h00;
		port = 1'b0;
		fs <= 1'b1;
		half();
		for (int k = 0; k < nb; k++) begin
			bclk <= 1'b1;
			if (k >= pos0 && k < pos0 + 8) begin
				b = rw[7 - (k - pos0)];
				rx_a <= b ^ rp;
				rx_b <= b ^ ~rp;
			end else begin
				rx_a <= k[0];
				rx_b <= ~k[0];
			end
			half();
			bclk <= 1'b0;
			fs <= 1'b0;
			if (tx_a_oe === 1'b1 || tx_b_oe === 1'b1) begin
				if (first < 0) begin
					first = k;
					port = tx_b_oe;
				end
				if (k - first < 8) begin
					word[7 - (k - first)] = port ? tx_b : tx_a;
				end
				n_oe++;
			end
			half();
		end
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// >>> pshc_pkg.sv
`default_nettype none
package pshc_pkg;

	// ----------------------------------------
	// first-byte register selects
	// ----------------------------------------
	localparam logic [7:0] CMD_TX_GAIN = 8'h40;
	localparam logic [7:0] CMD_RX_GAIN = 8'h50;
	localparam logic [7:0] CMD_ECHO_ONE = 8'h60;
	localparam logic [7:0] CMD_TX_SLOT = 8'h80;
	localparam logic [7:0] CMD_RX_SLOT = 8'h90;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SLOT_EN_BIT = 7;
	localparam int PORT_SEL_BIT = 6;
	localparam int CANCEL_EN_BIT = 7;
	localparam int PHASE_BIT = 6;
	localparam int FIRST_ORDER_BIT = 5;
	localparam int ATTEN_MSB = 4;
	localparam int SLOT_MSB = 5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] TX_GAIN_RST = 8'h00;
	localparam logic [7:0] RX_GAIN_RST = 8'h00;
	localparam logic [7:0] ECHO_ONE_RST = 8'h00;
	localparam logic [5:0] SLOT_RST = 6'h00;

	// ----------------------------------------
	// frame and byte counts
	// ----------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [9:0] POS_IDLE = 10'h200;
	localparam logic [9:0] POS_PROMPT = 10'h000;
	localparam logic [9:0] POS_DELAYED = 10'h3ff;
	localparam logic [1:0] APPLY_FRAMES = 2'h2;

	typedef enum logic [1:0] {
		PSHC_WAIT_CMD = 2'b01,
		PSHC_WAIT_DATA = 2'b10
	} pshc_stage_e;

endpackage
`default_nettype wire
